// >>> core/tirs_defs.vh
// Constants of the temperature result and status formatter.
// Included by every design file of this block; definitions only.
`ifndef TIRS_DEFS_VH
`define TIRS_DEFS_VH

// Channel count and field widths
`define TIRS_NCH          4
`define TIRS_WORD_W       16
`define TIRS_FLOAT_W      24
`define TIRS_STAT_W       8

// Channel type codes
`define TIRS_TYPE_TC      2'h0
`define TIRS_TYPE_VOLT    2'h1
`define TIRS_TYPE_RTD     2'h2
`define TIRS_TYPE_THERM   2'h3

// Status field positions inside one channel pair
`define TIRS_POS_RANGE    0
`define TIRS_POS_BURN     1

// Saturation limits of the integer result word
`define TIRS_WORD_MAX     16'h7FFF
`define TIRS_WORD_MIN     16'h8000

// Reset values
`define TIRS_STAT_RST     8'h00
`define TIRS_WORD_RST     16'h0000
`define TIRS_FLOAT_RST    24'h000000

// Status byte index after four channel words (first free byte)
`define TIRS_STAT_INDEX   8'h08

`endif

// >>> core/tirs_round.v
// Rounds a fixed-point reading (4 fraction bits) to a whole count and
// saturates it into a signed 16-bit word. Pure combinational logic.
`timescale 1ns/10ps
`default_nettype none
`include "tirs_defs.vh"

module tirs_round (
    // Reading, signed, 4 fraction bits
    input  wire [31:0] value_in,
    // Rounded and saturated word
    output reg  [15:0] word_out
);

    reg [31:0] rounded;

    // Round half away from zero, then clamp
    always @* begin
        if (value_in[31])
            rounded = $signed(value_in + 32'h00000007) >>> 4;
        else
            rounded = $signed(value_in + 32'h00000008) >>> 4;
        if ($signed(rounded) > $signed({16'h0000, `TIRS_WORD_MAX}))
            word_out = `TIRS_WORD_MAX;
        else if ($signed(rounded) < $signed({16'hFFFF, `TIRS_WORD_MIN}))
            word_out = `TIRS_WORD_MIN;
        else
            word_out = rounded[15:0];
    end

endmodule
`default_nettype wire

// >>> core/tirs_float.v
// Converts a signed fixed-point reading (4 fraction bits) into a 24-bit
// float: sign, 7-bit exponent (bias 63), 16-bit mantissa with hidden one.
`timescale 1ns/10ps
`default_nettype none
`include "tirs_defs.vh"

module tirs_float (
    // Reading, signed, 4 fraction bits
    input  wire [31:0] value_in,
    // 24-bit floating value
    output reg  [23:0] float_out
);

    reg [31:0] mag;
    reg [31:0] norm;
    reg [5:0]  lead;
    reg [6:0]  expo;
    integer    i;

    // Find leading one, normalise, build fields
    always @* begin
        mag  = value_in[31] ? (32'h00000000 - value_in) : value_in;
        lead = 6'h00;
        for (i = 0; i < 32; i = i + 1) begin
            if (mag[i])
                lead = i[5:0];
        end
        norm = mag << (6'h1F - lead);
        expo = 7'h3F + {1'b0, lead} - 7'h04;
        if (mag == 32'h00000000)
            float_out = `TIRS_FLOAT_RST;
        else
            float_out = {value_in[31], expo, norm[30:15]};
    end

endmodule
`default_nettype wire

// >>> core/tirs_result_status.v
// Result formatter and fault status for a four-channel temperature input.
// Assumes the converter hands one finished reading per strobe, already
// linearised in the selected scale, with its range and open-loop flags.
`timescale 1ns/10ps
`default_nettype none
`include "tirs_defs.vh"

// Overview of operation
// - Temperature channels report whole degrees in the word.
// - The temperature is rounded to a whole count before storing it.
// - Each channel also gets a 24-bit floating copy of its reading.
// - Voltage channels report signed raw counts from -32768 to 32767.
// - The word saturates at 32767 while the float keeps the full value.
// - The status byte sits in the first free byte after the words.
// - Each channel owns a flag pair, range low and burnout high, ch1 LSB.
// - Out-of-range follows whether the input is outside its range.
// - Burnout is set while the loop is open and detection is enabled.
// - Only enabled channels are converted and reported.
// - Type and range are chosen per channel independently.
// - A module-wide select picks Fahrenheit or Celsius.
module tirs_result_status (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // Configuration from the host
    input  wire [3:0]  chan_enable,
    input  wire [7:0]  chan_type,
    input  wire [15:0] chan_range,
    input  wire        scale_fahrenheit,
    input  wire        burnout_enable,
    input  wire        mains_select,
    // Reading from the converter
    input  wire        conv_valid,
    input  wire [1:0]  conv_chan,
    input  wire [31:0] conv_value,
    input  wire        conv_out_of_range,
    input  wire        conv_loop_open,
    // Requests to the converter
    output wire [3:0]  conv_chan_enable,
    output wire [7:0]  conv_chan_type,
    output wire [15:0] conv_chan_range,
    output wire        conv_scale_fahrenheit,
    output wire        conv_mains_select,
    // Results to the host
    output reg  [63:0] integer_result_word,
    output reg  [95:0] float_result_value,
    output reg  [7:0]  channel_fault_status,
    output wire [7:0]  status_byte_index,
    output reg         result_update
);

    // Reset synchroniser stages
    reg         rst_meta;
    reg         rst_sync;

    // Converted forms of the current reading
    wire [15:0] word_rounded;
    wire [23:0] float_value;
    reg  [15:0] word_raw;
    reg  [15:0] next_word;

    // Raw counts beyond the signed word span
    reg         raw_above;
    reg         raw_below;

    // Acceptance and channel decode
    wire        take;
    wire [3:0]  chan_onehot;
    wire [3:0]  chan_hit;
    wire [3:0]  chan_is_volt;
    wire        sel_is_volt;

    // Flag pair of the current reading
    wire        next_range;
    wire        next_burn;

    // Next contents of the result registers
    wire [63:0] next_word_bank;
    wire [95:0] next_float_bank;
    wire [7:0]  next_status;
    wire        next_update;

    // Channel loop index
    genvar      g;

    // Reset release through two flops
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign conv_chan_type        = chan_type;
    assign conv_chan_range       = chan_range;
    assign conv_scale_fahrenheit = scale_fahrenheit;
    assign conv_mains_select     = mains_select;
    assign conv_chan_enable      = chan_enable;

    assign status_byte_index = `TIRS_STAT_INDEX;

    tirs_round u_round (
        .value_in (conv_value),
        .word_out (word_rounded)
    );

    tirs_float u_float (
        .value_in  (conv_value),
        .float_out (float_value)
    );

    assign take        = conv_valid && chan_enable[conv_chan];
    assign chan_onehot = 4'h1 << conv_chan;
    assign chan_hit    = take ? chan_onehot : 4'h0;
    assign next_update = take;

    generate
        for (g = 0; g < `TIRS_NCH; g = g + 1) begin : g_type
            assign chan_is_volt[g] =
                (chan_type[g*2 +: 2] == `TIRS_TYPE_VOLT);
        end
    endgenerate

    // Type of the channel being read
    assign sel_is_volt = chan_is_volt[conv_chan];

    // detect raw counts outside the word span
    always @* begin
        raw_above = 1'b0;
        raw_below = 1'b0;
        if (conv_value[31]) begin
            if ($signed(conv_value) < $signed({16'hFFFF, `TIRS_WORD_MIN}))
                raw_below = 1'b1;
        end else begin
            if (conv_value > {16'h0000, `TIRS_WORD_MAX})
                raw_above = 1'b1;
        end
    end

    // raw counts saturate at the word limits
    always @* begin
        if (raw_above)
            word_raw = `TIRS_WORD_MAX;
        else if (raw_below)
            word_raw = `TIRS_WORD_MIN;
        else
            word_raw = conv_value[15:0];
    end

    always @* begin
        if (sel_is_volt)
            next_word = word_raw;
        else
            next_word = word_rounded;
    end

    assign next_range = conv_out_of_range;
    assign next_burn  = burnout_enable & conv_loop_open;

    // slots of one channel switch on the same hit
    generate
        for (g = 0; g < `TIRS_NCH; g = g + 1) begin : g_slot
            // Slot contents chosen for the next edge
            reg [15:0] slot_word;
            reg [23:0] slot_float;
            reg        slot_range;
            reg        slot_burn;

            always @* begin
                if (chan_hit[g])
                    slot_word = next_word;
                else
                    slot_word = integer_result_word[g*16 +: 16];
            end

            always @* begin
                if (chan_hit[g])
                    slot_float = float_value;
                else
                    slot_float = float_result_value[g*24 +: 24];
            end

            always @* begin
                if (chan_hit[g])
                    slot_range = next_range;
                else
                    slot_range = channel_fault_status[g*2 +
                        `TIRS_POS_RANGE];
            end

            always @* begin
                if (chan_hit[g])
                    slot_burn = next_burn;
                else
                    slot_burn = channel_fault_status[g*2 +
                        `TIRS_POS_BURN];
            end

            // Gather this channel's slots into the banks
            assign next_word_bank[g*16 +: 16]         = slot_word;
            assign next_float_bank[g*24 +: 24]        = slot_float;
            assign next_status[g*2 + `TIRS_POS_RANGE] = slot_range;
            assign next_status[g*2 + `TIRS_POS_BURN]  = slot_burn;
        end
    endgenerate

    // word bank loads with the rest
    always @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync)
            integer_result_word <= {4{`TIRS_WORD_RST}};
        else
            integer_result_word <= next_word_bank;
    end

    // float bank loads with the rest
    always @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync)
            float_result_value <= {4{`TIRS_FLOAT_RST}};
        else
            float_result_value <= next_float_bank;
    end

    // status pairs load with the rest
    always @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync)
            channel_fault_status <= `TIRS_STAT_RST;
        else
            channel_fault_status <= next_status;
    end

    // Update pulse one cycle after acceptance
    always @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync)
            result_update <= 1'b0;
        else
            result_update <= next_update;
    end

endmodule
`default_nettype wire

// >>> tb/tirs_conv_model.sv
// Converter model: hands the formatter one reading per call of send.
// Assumes a free-running ref_clk; lines scramble once valid drops.
`timescale 1ns/10ps
`default_nettype none
module tirs_conv_model (
    // Clock
    input  wire logic        ref_clk,
    // Reading to the formatter
    output logic             conv_valid,
    output logic [1:0]       conv_chan,
    output logic [31:0]      conv_value,
    output logic             conv_out_of_range,
    output logic             conv_loop_open
);
    // Idle lines at start
    initial begin
        conv_valid = 1'b0;
        conv_chan = 2'h0;
        conv_value = 32'h0;
        conv_out_of_range = 1'b0;
        conv_loop_open = 1'b0;
    end
    // One-cycle reading, then stale data is inverted
    task send(input logic [1:0] c, input logic [31:0] v, input logic o, b);
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_chan <= c;
        conv_value <= v;
        conv_out_of_range <= o;
        conv_loop_open <= b;
        @(posedge ref_clk);
        conv_valid <= 1'b0;
        conv_chan <= ~c;
        conv_value <= ~v;
        conv_out_of_range <= ~o;
        conv_loop_open <= ~b;
    endtask
endmodule
`default_nettype wire

// >>> tb/tirs_monitor.sv
// Checker on the formatter's ports: update timing, flags, clamping.
// Assumes it is bound into every formatter instance.
`timescale 1ns/10ps
`default_nettype none
module tirs_monitor (
    // Clock, reset, config
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  chan_enable,
    input wire logic        scale_fahrenheit,
    input wire logic        burnout_enable,
    // Reading and results
    input wire logic        conv_valid,
    input wire logic [1:0]  conv_chan,
    input wire logic [31:0] conv_value,
    input wire logic        conv_out_of_range,
    input wire logic        conv_loop_open,
    input wire logic        conv_scale_fahrenheit,
    input wire logic [63:0] integer_result_word,
    input wire logic [7:0]  channel_fault_status,
    input wire logic [7:0]  status_byte_index,
    input wire logic        result_update
);
    // Accepted reading
    wire acc = conv_valid && chan_enable[conv_chan];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_update_taken: assert property (acc |=> result_update)
        else $error("update missing");
    a_update_quiet: assert property (!acc |=> !result_update)
        else $error("stray update");
    a_range_flag: assert property (acc |=>
        channel_fault_status[2*$past(conv_chan)] == $past(conv_out_of_range))
        else $error("range flag wrong");
    a_burn_flag: assert property (acc |=>
        channel_fault_status[2*$past(conv_chan)+1] ==
        ($past(conv_loop_open) && $past(burnout_enable)))
        else $error("burnout flag wrong");
    a_refused_hold: assert property (!acc |=>
        $stable(channel_fault_status) && $stable(integer_result_word))
        else $error("results moved");
    a_word_clamp: assert property (acc && $signed(conv_value) > 32'sh7FFFF
        |=> integer_result_word[16*$past(conv_chan)+:16] == 16'h7FFF)
        else $error("no clamp");
    a_status_place: assert property (status_byte_index == 8'h08)
        else $error("status index wrong");
    a_scale_pass: assert property (conv_scale_fahrenheit == scale_fahrenheit)
        else $error("scale not passed");
endmodule
bind tirs_result_status tirs_monitor tirs_monitor_i (.*);
`default_nettype wire

// >>> tb/temp_input_result_and_status_test.sv
// Bench: readings on every channel type, then word, float and flag checks.
// Assumes the converter model drives conv_* and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module temp_input_result_and_status_test;
    // Configuration and results
    logic        ref_clk = 1'b0, rst_n = 1'b0, burnout_enable = 1'b0;
    logic        scale_fahrenheit = 1'b0, mains_select = 1'b0;
    logic [3:0]  chan_enable = 4'hF;
    logic [7:0]  chan_type = 8'hE4;
    logic [15:0] chan_range = 16'h3210;
    wire  [3:0]  conv_chan_enable;
    wire  [7:0]  conv_chan_type, channel_fault_status, status_byte_index;
    wire  [15:0] conv_chan_range;
    wire  [63:0] integer_result_word;
    wire  [95:0] float_result_value;
    wire  [31:0] conv_value;
    wire  [1:0]  conv_chan;
    wire         conv_valid, conv_out_of_range, conv_loop_open, result_update;
    wire         conv_scale_fahrenheit, conv_mains_select;
    int          n_fail = 0, cmp_count = 0;
    tirs_result_status tirs_result_status_i (.*);
    tirs_conv_model tirs_conv_model_i (.*);
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // Compare and report
    task chk(input logic [95:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Reading taken at send's last edge; results settle just after it
    task put(input logic [1:0] c, input logic [31:0] v, input logic o, b, u);
        tirs_conv_model_i.send(c, v, o, b);
        #1;
        chk(result_update, u);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence; types TC, volt, RTD, thermistor per channel
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(channel_fault_status, 8'h00);
        chk(status_byte_index, 8'h08);
        chk(conv_chan_type, 8'hE4);
        chk(conv_chan_range, 16'h3210);
        put(0, 32'd4056, 0, 0, 1);
        chk(integer_result_word[15:0], 16'h00FE);
        chk(float_result_value[23:0], 24'h46FB00);
        put(1, 32'hFFFF8000, 0, 0, 1);
        chk(integer_result_word[31:16], 16'h8000);
        chk(float_result_value[47:24], 24'hCA0000);
        put(0, 32'hFFFFFFF9, 0, 0, 1);
        chk(integer_result_word[15:0], 16'h0000);
        chk(float_result_value[23:0], 24'hBDC000);
        put(0, 32'hFFFFFFF8, 0, 0, 1);
        chk(integer_result_word[15:0], 16'hFFFF);
        put(2, 32'd529280, 0, 0, 1);
        chk(integer_result_word[47:32], 16'h7FFF);
        chk(float_result_value[71:48], 24'h4E0270);
        @(posedge ref_clk) burnout_enable <= 1'b1;
        mains_select <= 1'b1;
        scale_fahrenheit <= 1'b1;
        put(3, 0, 1, 1, 1);
        chk(channel_fault_status, 8'hC0);
        chk(conv_mains_select, 1'b1);
        chk(conv_scale_fahrenheit, 1'b1);
        chk(float_result_value[95:72], 24'h000000);
        put(1, 0, 1, 0, 1);
        chk(channel_fault_status, 8'hC4);
        @(posedge ref_clk) burnout_enable <= 1'b0;
        put(0, 0, 0, 1, 1);
        chk(channel_fault_status, 8'hC4);
        put(3, 0, 0, 0, 1);
        chk(channel_fault_status, 8'h04);
        @(posedge ref_clk) chan_enable <= 4'h7;
        put(3, 32'd160, 1, 1, 0);
        chk(channel_fault_status, 8'h04);
        chk(conv_chan_enable, 4'h7);
        wrap_up();
    end
    // Watchdog, far beyond the some 31 cycles (about 310 ns) the tests need
    initial begin
        #50000;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
